/* File: design/watchdog_and_address_trap.v */
// Watchdog timer and instruction-fetch address trap supervisor
//
// Operation
// - Binary counter held cleared while the watchdog is disabled.
// - Two-bit time field selects overflow period, fc or fs based.
// - Output select 0: counter overflow raises watchdog interrupt request.
// - Watchdog interrupt is non-maskable, ignores the master flag.
// - New watchdog interrupt taken at once even during another service.
// - Output select 1: counter overflow raises reset request instead.
// - Reset request drives reset pin low, resets hardware, at most 24/fc.
// - Reset in low speed mode one restarts fast oscillator, same bound.
// - RAM trap select takes effect only after the trap-enable code.
// - Fetches from special function or debug areas always trap.
// - Trap action bit chooses interrupt or reset on an address trap.
// - Trap action 0: trapped fetch raises address trap interrupt.
// - Address trap interrupt is non-maskable, ignores the master flag.
// - New trap interrupt taken at once even during another service.
// - Trap action 1: trapped fetch causes reset, same as watchdog reset.
// - Enable bit is set by reset, so the watchdog runs after release.
// - Disable code honoured only while the enable bit is 0.
// - Once output select is cleared it cannot be set again until reset.
//
// Local design decisions: register access over AHB-Lite and the address map.
`include "wdt_trap_defines.vh"
`default_nettype none

module watchdog_and_address_trap (
    input wire core_clk,
    input wire rst_b,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output wire [31:0] hrdata,
    input wire fcTick,
    input wire fsTick,
    input wire lowSpeedModeOne,
    input wire fetchValid,
    input wire [15:0] fetchAddr,
    output reg dogOverflowIrq,
    output reg fetchTrapIrq,
    output reg resetPinOut,
    output reg resetPinOe,
    output reg internalResetReq,
    output reg oscRestart
);

    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    localparam [1:0] S_RUN = 2'b01;
    localparam [1:0] S_RST = 2'b10;

    // ------------------------------------------------------------
    // Register bus front end
    // ------------------------------------------------------------
    wire wrEn;
    wire [31:0] wrAddr;
    wire [31:0] wrData;
    wire [31:0] rdAddr;
    reg [31:0] rdData;

    ahb_reg_slave busSlave (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .wrEn(wrEn),
        .wrAddr(wrAddr),
        .wrData(wrData),
        .rdAddr(rdAddr),
        .rdData(rdData)
    );

    // ------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------
    reg [7:0] ctrl_q;
    reg [7:0] ctrl_d;
    reg dogOn_q;
    reg dogOn_d;
    reg ramTrapLive_q;
    reg ramTrapLive_d;
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [`RST_CNT_W-1:0] rstCnt_q;
    reg [`RST_CNT_W-1:0] rstCnt_d;

    wire [`CNT_W-1:0] count;
    wire overflow;
    wire [31:0] rstLoad = `RST_CYCLES - 1;

    wire inRun = (state_q == S_RUN);
    wire ctrlWr = inRun && wrEn && (wrAddr == `REG_CTRL);
    wire codeWr = inRun && wrEn && (wrAddr == `REG_CODE);
    wire [7:0] code = wrData[7:0];

    wire clearCode = codeWr && (code == `CODE_CLEAR);
    // Disable code only while the enable bit is already 0
    wire disableCode = codeWr && (code == `CODE_DISABLE)
        && !ctrl_q[`BIT_EN];
    wire trapEnCode = codeWr && (code == `CODE_TRAPEN);

    // Counter runs from fs in low speed mode or with source select 1
    wire useFs = lowSpeedModeOne || ctrl_q[`BIT_SRC];
    wire cntClear = !dogOn_q || clearCode || !inRun;

    overflow_counter dogCounter (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .clear(cntClear),
        .fcTick(fcTick),
        .fsTick(fsTick),
        .useFs(useFs),
        .timeSel(ctrl_q[`FLD_TIME_LO+1:`FLD_TIME_LO]),
        .count(count),
        .overflow(overflow)
    );

    // ------------------------------------------------------------
    // Fetch area decode
    // ------------------------------------------------------------
    function inArea;
        input [15:0] a;
        input [15:0] lo;
        input [15:0] hi;
        begin
            inArea = (a >= lo) && (a <= hi);
        end
    endfunction

    wire hitSfr = inArea(fetchAddr, `SFR_LO, `SFR_HI);
    wire hitDbr = inArea(fetchAddr, `DBR_LO, `DBR_HI);
    wire hitRam = inArea(fetchAddr, `RAM_LO, `RAM_HI);

    // System areas trap unconditionally, RAM only when armed
    wire trapHit = inRun && fetchValid
        && (hitSfr || hitDbr || (hitRam && ramTrapLive_q));

    // Overflow only counts while running and enabled
    wire dogEvent = inRun && dogOn_q && overflow;

    // Either source can request reset
    wire dogReset = dogEvent && ctrl_q[`BIT_OUTSEL];
    wire trapReset = trapHit && ctrl_q[`BIT_ACT];
    wire startReset = dogReset || trapReset;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always @* begin
        ctrl_d = ctrl_q;
        dogOn_d = dogOn_q;
        ramTrapLive_d = ramTrapLive_q;
        state_d = state_q;
        rstCnt_d = rstCnt_q;
        case (state_q)
            S_RUN: begin
                if (startReset) begin
                    // Internal hardware reset: controls return to reset values
                    state_d = S_RST;
                    rstCnt_d = rstLoad[`RST_CNT_W-1:0];
                    ctrl_d = `CTRL_RESET;
                    dogOn_d = 1'b1;
                    ramTrapLive_d = 1'b1;
                end else begin
                    if (ctrlWr) begin
                        ctrl_d = wrData[7:0];
                        // Output select can only be cleared
                        ctrl_d[`BIT_OUTSEL] = wrData[`BIT_OUTSEL]
                            & ctrl_q[`BIT_OUTSEL];
                        if (wrData[`BIT_EN]) begin
                            dogOn_d = 1'b1;
                        end
                    end
                    if (disableCode) begin
                        dogOn_d = 1'b0;
                    end
                    // New RAM trap setting becomes live on the code
                    if (trapEnCode) begin
                        ramTrapLive_d = ctrl_q[`BIT_RAMTRAP];
                    end
                    // Any other code value falls through untouched
                end
            end
            S_RST: begin
                if (rstCnt_q == {`RST_CNT_W{1'b0}}) begin
                    state_d = S_RUN;
                end else begin
                    rstCnt_d = rstCnt_q - {{(`RST_CNT_W-1){1'b0}}, 1'b1};
                end
            end
            default: begin
                state_d = S_RUN;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Register state and outputs
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        if (!rst_b) begin
            ctrl_q <= `CTRL_RESET;
            dogOn_q <= 1'b1;
            ramTrapLive_q <= 1'b1;
            state_q <= S_RUN;
            rstCnt_q <= {`RST_CNT_W{1'b0}};
            dogOverflowIrq <= 1'b0;
            fetchTrapIrq <= 1'b0;
            resetPinOut <= 1'b0;
            resetPinOe <= 1'b0;
            internalResetReq <= 1'b0;
            oscRestart <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            dogOn_q <= dogOn_d;
            ramTrapLive_q <= ramTrapLive_d;
            state_q <= state_d;
            rstCnt_q <= rstCnt_d;
            // Non-maskable: no master flag, no busy gating
            dogOverflowIrq <= dogEvent
                && !ctrl_q[`BIT_OUTSEL];
            fetchTrapIrq <= trapHit && !ctrl_q[`BIT_ACT]
                && !dogReset;
            // Open-drain reset pin pulled low for the pulse
            resetPinOut <= 1'b0;
            resetPinOe <= (state_d == S_RST);
            internalResetReq <= (state_d == S_RST);
            oscRestart <= startReset && lowSpeedModeOne;
        end
    end

    // ------------------------------------------------------------
    // Register read mux
    // ------------------------------------------------------------
    always @* begin
        case (rdAddr)
            `REG_CTRL: rdData = {24'h000000, ctrl_q};
            `REG_STAT: rdData = {28'h0000000, state_q[1], useFs,
                ramTrapLive_q, dogOn_q};
            `REG_CNT: rdData = {{(32-`CNT_W){1'b0}}, count};
            default: rdData = 32'h0000_0000;
        endcase
    end

endmodule
`default_nettype wire

/* File: common/wdt_trap_defines.vh */
// Constants for the watchdog and address-trap supervisor
`ifndef WDT_TRAP_DEFINES_VH
`define WDT_TRAP_DEFINES_VH

// Register byte addresses
`define REG_CTRL 32'h0000_0000
`define REG_CODE 32'h0000_0004
`define REG_STAT 32'h0000_0008
`define REG_CNT 32'h0000_000c

// supervisor_control_reg fields and reset value
`define BIT_OUTSEL 0
`define FLD_TIME_LO 1
`define BIT_EN 3
`define BIT_SRC 4
`define BIT_ACT 5
`define BIT_RAMTRAP 6
`define CTRL_RESET 8'h79

// supervisor_code_reg codes
`define CODE_CLEAR 8'h4e
`define CODE_DISABLE 8'hb1
`define CODE_TRAPEN 8'hd2

// Binary counter: fc stages 25/23/21/19, fs stages 17/15/13/11
`define CNT_W 25
`define FS_EXTRA_SHIFT 5'd8

// Reset pulse: 24/fc at fc = 16 MHz
`define RST_TIME_NS 1500
`define CLK_PERIOD_NS 4
`define RST_CYCLES (`RST_TIME_NS / `CLK_PERIOD_NS)
`define RST_CNT_W 9

// Fetch address areas
`define SFR_LO 16'h0000
`define SFR_HI 16'h003f
`define RAM_LO 16'h0040
`define RAM_HI 16'h023f
`define DBR_LO 16'h0f80
`define DBR_HI 16'h0fff

`endif

/* File: design/ahb_reg_slave.v */
// AHB-Lite slave front end, zero wait states, single word transfers
`include "wdt_trap_defines.vh"
`default_nettype none

module ahb_reg_slave (
    input wire core_clk,
    input wire rst_b,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata,
    output wire wrEn,
    output reg [31:0] wrAddr,
    output wire [31:0] wrData,
    output wire [31:0] rdAddr,
    input wire [31:0] rdData
);

    // ------------------------------------------------------------
    // Address phase capture
    // ------------------------------------------------------------
    wire take = hsel && htrans[1] && hready;
    wire wordOk = (hsize == 3'b010) && (haddr[1:0] == 2'b00);
    reg wrPend_q;

    assign rdAddr = haddr;
    assign wrEn = wrPend_q;
    assign wrData = hwdata;

    always @(posedge core_clk) begin
        if (!rst_b) begin
            wrPend_q <= 1'b0;
            wrAddr <= 32'h0000_0000;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wrPend_q <= take && hwrite && wordOk;
            if (take) begin
                wrAddr <= haddr;
            end
            // Read data stands during the data phase
            if (take && !hwrite) begin
                hrdata <= wordOk ? rdData : 32'h0000_0000;
            end
        end
    end

endmodule
`default_nettype wire

/* File: design/overflow_counter.v */
// Watchdog binary counter with selectable overflow stage
`include "wdt_trap_defines.vh"
`default_nettype none

module overflow_counter (
    input wire core_clk,
    input wire rst_b,
    input wire clear,
    input wire fcTick,
    input wire fsTick,
    input wire useFs,
    input wire [1:0] timeSel,
    output reg [`CNT_W-1:0] count,
    output reg overflow
);

    // Last count before overflow: 2^stage - 1
    function [`CNT_W-1:0] lastCount;
        input fs;
        input [1:0] sel;
        reg [4:0] sh;
        begin
            sh = {2'b00, sel, 1'b0};
            if (fs) begin
                sh = sh + `FS_EXTRA_SHIFT;
            end
            lastCount = {`CNT_W{1'b1}} >> sh;
        end
    endfunction

    wire tick = useFs ? fsTick : fcTick;

    always @(posedge core_clk) begin
        if (!rst_b) begin
            count <= {`CNT_W{1'b0}};
            overflow <= 1'b0;
        end else begin
            overflow <= 1'b0;
            if (clear) begin
                count <= {`CNT_W{1'b0}};
            end else if (tick) begin
                // Shortened time select takes effect at once
                if (count >= lastCount(useFs, timeSel)) begin
                    count <= {`CNT_W{1'b0}};
                    overflow <= 1'b1;
                end else begin
                    count <= count + {{(`CNT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule
`default_nettype wire

/* File: sim/wdt_trap_props.sv */
// Concurrent checks on the supervisor's top-level ports
`include "wdt_trap_defines.vh"
`default_nettype none
module wdt_trap_props (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic lowSpeedModeOne,
    input wire logic fetchValid,
    input wire logic [15:0] fetchAddr,
    input wire logic dogOverflowIrq,
    input wire logic fetchTrapIrq,
    input wire logic resetPinOut,
    input wire logic resetPinOe,
    input wire logic internalResetReq,
    input wire logic oscRestart
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // Reset pulse length and trap relations
    // ----------------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    logic [8:0] pulseLenQ;
    logic [8:0] pulseLenD;
    wire logic fixedArea;
    assign fixedArea = fetchAddr <= `SFR_HI || (fetchAddr >= `DBR_LO && fetchAddr <= `DBR_HI);
    assign pulseLenD = resetPinOe ? pulseLenQ + 9'h001 : 9'h000;
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            pulseLenQ <= 9'h000;
        end else begin
            pulseLenQ <= pulseLenD;
        end
    end
    sequence trapFetch;
        fetchValid && fixedArea && !resetPinOe;
    endsequence
    sequence trapAnswer;
        fetchTrapIrq || resetPinOe;
    endsequence
    a_reset_pin_low: assert property (resetPinOe |-> !resetPinOut)
        else $error("reset pin not driven low");
    a_reset_pair_same: assert property (internalResetReq == resetPinOe)
        else $error("internal reset differs from pin");
    a_pulse_max_len: assert property (resetPinOe |-> pulseLenQ < `RST_CYCLES)
        else $error("reset pulse too long");
    a_pulse_full_len: assert property (
        $fell(resetPinOe) |-> pulseLenQ == `RST_CYCLES)
        else $error("reset pulse length wrong");
    a_fixed_area_trap: assert property (trapFetch |=> trapAnswer)
        else $error("fixed area fetch not trapped");
    a_trap_has_cause: assert property (
        fetchTrapIrq |-> $past(fetchValid) && !$past(resetPinOe))
        else $error("trap request without fetch");
    a_quiet_in_pulse: assert property (
        resetPinOe && $past(resetPinOe) |-> !fetchTrapIrq && !dogOverflowIrq)
        else $error("request during reset pulse");
    a_dog_irq_single: assert property (dogOverflowIrq |=> !dogOverflowIrq)
        else $error("watchdog request longer than one cycle");
    a_osc_at_start: assert property (oscRestart |-> $rose(resetPinOe))
        else $error("oscillator restart outside pulse start");
    a_osc_when_slow: assert property (
        $rose(resetPinOe) |-> oscRestart == $past(lowSpeedModeOne))
        else $error("oscillator restart mismatch");
    a_bus_ready_okay: assert property ($past(rst_b) |-> hreadyout && !hresp)
        else $error("bus not ready or not okay");
endmodule
bind watchdog_and_address_trap wdt_trap_props i_props (.core_clk, .rst_b, .hreadyout, .hresp,
    .lowSpeedModeOne, .fetchValid, .fetchAddr, .dogOverflowIrq, .fetchTrapIrq, .resetPinOut,
    .resetPinOe, .internalResetReq, .oscRestart);
`default_nettype wire

/* File: sim/cpu_model.sv */
// CPU core model: bus master, instruction fetches and NMI acceptance
`include "wdt_trap_defines.vh"
`default_nettype none
module cpu_model (
    input wire logic core_clk,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic dogOverflowIrq,
    input wire logic fetchTrapIrq,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    output logic fetchValid,
    output logic [15:0] fetchAddr
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // NMIs nest whatever the master flag holds
    // ----------------------------------------------------------------
    logic imfQ = 1'b1;
    logic stackSetQ = 1'b0;
    int nmiDepth = 0;
    always @(posedge core_clk) begin
        if (dogOverflowIrq || fetchTrapIrq) begin
            nmiDepth <= nmiDepth + 1;
        end
    end
    initial begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        fetchValid = 1'b0;
        fetchAddr = 16'h0000;
    end
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        haddr <= ~a;
        hwdata <= wd;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        hwdata <= ~wd;
    endtask
    task automatic armNmi(input logic [7:0] ctrl);
        logic [31:0] d;
        stackSetQ = 1'b1;
        xfer(1'b1, `REG_CTRL, {24'h000000, ctrl}, d);
    endtask
    task automatic dogOff(input logic [7:0] ctrl);
        logic [31:0] d;
        imfQ = 1'b0;
        xfer(1'b1, `REG_CODE, {24'h000000, `CODE_CLEAR}, d);
        xfer(1'b1, `REG_CTRL, {24'h000000, ctrl & 8'hf7}, d);
        xfer(1'b1, `REG_CODE, {24'h000000, `CODE_DISABLE}, d);
    endtask
    task automatic fetch(input logic [15:0] a);
        fetchValid <= 1'b1;
        fetchAddr <= a;
        @(posedge core_clk);
        fetchValid <= 1'b0;
        fetchAddr <= ~a;
    endtask
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench for the watchdog and address-trap supervisor
`include "wdt_trap_defines.vh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // Harness, compares and scenarios
    // ----------------------------------------------------------------
    logic core_clk = 1'b0, rst_b = 1'b0, fcTick = 1'b0, fsTick = 1'b1, lowSpeedModeOne = 1'b0;
    logic hsel, hwrite, fetchValid, dogOverflowIrq, fetchTrapIrq, resetPinOut, resetPinOe;
    logic hreadyout, hresp, internalResetReq, oscRestart;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] fetchAddr;
    int nErrors = 0, checkCount = 0, cycles = 0;
    always #2 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        fcTick <= ~fcTick;
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            nErrors++;
            endSim();
        end
    end
    watchdog_and_address_trap i_dut (.core_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .fcTick, .fsTick,
        .lowSpeedModeOne, .fetchValid, .fetchAddr, .dogOverflowIrq, .fetchTrapIrq, .resetPinOut,
        .resetPinOe, .internalResetReq, .oscRestart);
    cpu_model i_cpu (.core_clk, .hreadyout, .hrdata, .dogOverflowIrq, .fetchTrapIrq, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata, .fetchValid, .fetchAddr);
    task automatic endSim();
        $display("checks %0d errors %0d", checkCount, nErrors);
        if (nErrors == 0 && checkCount > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checkCount++;
        if (got !== exp) begin
            nErrors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic checkBit(input string what, input logic exp, input logic got);
        check(what, {31'h0, exp}, {31'h0, got});
    endtask
    task automatic checkRange(input string what, input int lo, input int hi, input int got);
        checkCount++;
        if (got < lo || got > hi) begin
            nErrors++;
            $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [7:0] v);
        logic [31:0] d;
        i_cpu.xfer(1'b1, a, {24'h000000, v}, d);
    endtask
    task automatic rdCheck(input string what, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        i_cpu.xfer(1'b0, a, 32'h0000_0000, d);
        check(what, exp, d);
    endtask
    task automatic fetchCheck(input logic [15:0] a, input logic exp);
        i_cpu.fetch(a);
        #1;
        checkBit("trap irq", exp, fetchTrapIrq);
        @(posedge core_clk);
    endtask
    task automatic dogGap(input logic [7:0] code, output int n);
        int t0;
        do @(posedge core_clk); while (dogOverflowIrq !== 1'b1);
        t0 = cycles;
        repeat (1000) @(posedge core_clk);
        wr(`REG_CODE, code);
        do @(posedge core_clk); while (dogOverflowIrq !== 1'b1);
        n = cycles - t0;
    endtask
    task automatic tDogReset();
        int t0;
        lowSpeedModeOne <= 1'b1;
        wr(`REG_CTRL, 8'h7f);
        do @(posedge core_clk); while (resetPinOe !== 1'b1);
        t0 = cycles;
        checkBit("osc restart", 1'b1, oscRestart);
        checkBit("internal reset", 1'b1, internalResetReq);
        check("no dog irq", 32'h0, i_cpu.nmiDepth);
        wr(`REG_CTRL, 8'h7e);
        while (resetPinOe === 1'b1) @(posedge core_clk);
        check("pulse cycles", `RST_CYCLES, cycles - t0);
        lowSpeedModeOne <= 1'b0;
        rdCheck("ctrl reload", `REG_CTRL, 32'h79);
    endtask
    task automatic tDogIrq();
        int n;
        i_cpu.armNmi(8'h7e);
        rdCheck("ctrl", `REG_CTRL, 32'h7e);
        dogGap(8'h55, n);
        check("period 11", 2048, n);
        dogGap(`CODE_CLEAR, n);
        checkRange("clear restart", 3046, 3056, n);
        wr(`REG_CTRL, 8'h7d);
        rdCheck("outsel stays 0", `REG_CTRL, 32'h7c);
        dogGap(8'h00, n);
        check("period 10", 8192, n);
        @(posedge core_clk);
        check("nmi nesting", 32'h0000_0006, i_cpu.nmiDepth);
    endtask
    task automatic tDisable();
        int depth;
        wr(`REG_CODE, `CODE_DISABLE);
        rdCheck("still running", `REG_STAT, 32'h7);
        i_cpu.dogOff(8'h7c);
        depth = i_cpu.nmiDepth;
        repeat (9000) @(posedge core_clk);
        rdCheck("stopped", `REG_STAT, 32'h6);
        rdCheck("count held", `REG_CNT, 32'h0);
        check("no overflow", depth, i_cpu.nmiDepth);
    endtask
    task automatic tTraps();
        logic [15:0] addrs [9] = '{16'h0010, 16'h003f, 16'h0040, 16'h023f, 16'h0240,
                                   16'h0f7f, 16'h0f80, 16'h0fff, 16'h1000};
        logic [8:0] expBits = 9'b111100110;
        int depth;
        depth = i_cpu.nmiDepth;
        wr(`REG_CTRL, 8'h54);
        for (int i = 0; i < 9; i++) begin
            fetchCheck(addrs[i], expBits[8 - i]);
        end
        check("traps taken", depth + 6, i_cpu.nmiDepth);
        wr(`REG_CTRL, 8'h14);
        fetchCheck(16'h0100, 1'b1);
        wr(`REG_CODE, `CODE_TRAPEN);
        rdCheck("ram trap off", `REG_STAT, 32'h4);
        fetchCheck(16'h0100, 1'b0);
        fetchCheck(16'h0020, 1'b1);
        wr(`REG_CTRL, 8'h34);
        i_cpu.fetch(16'h0fc0);
        #1;
        checkBit("trap reset", 1'b1, resetPinOe);
        checkBit("no trap irq", 1'b0, fetchTrapIrq);
        checkBit("no osc restart", 1'b0, oscRestart);
        @(posedge core_clk);
        while (resetPinOe === 1'b1) @(posedge core_clk);
        rdCheck("ctrl after trap", `REG_CTRL, 32'h79);
    endtask
    task automatic tSource();
        logic [31:0] c0, c1;
        wr(`REG_CTRL, 8'h69);
        i_cpu.xfer(1'b0, `REG_CNT, 32'h0000_0000, c0);
        repeat (98) @(posedge core_clk);
        i_cpu.xfer(1'b0, `REG_CNT, 32'h0000_0000, c1);
        check("fc ticks", 32'h0000_0032, c1 - c0);
        lowSpeedModeOne <= 1'b1;
        i_cpu.xfer(1'b0, `REG_CNT, 32'h0000_0000, c0);
        repeat (98) @(posedge core_clk);
        i_cpu.xfer(1'b0, `REG_CNT, 32'h0000_0000, c1);
        check("slow mode ticks", 32'h0000_0064, c1 - c0);
        lowSpeedModeOne <= 1'b0;
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge core_clk);
        rdCheck("ctrl reset", `REG_CTRL, 32'h79);
        rdCheck("status reset", `REG_STAT, 32'h7);
        rdCheck("code reads 0", `REG_CODE, 32'h0);
        rdCheck("unmapped", 32'h0000_0010, 32'h0);
        tDogReset();
        tDogIrq();
        tDisable();
        tTraps();
        tSource();
        endSim();
    end
endmodule
`default_nettype wire
